// [common/tw_pkg.sv]
// constants, field layout and types shared by the two-wire master transmitter
package tw_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int SCL_PERIOD_NS = 200;
  // quarter of a bus bit, least time, so rounded up
  localparam int QUARTER_NS    = SCL_PERIOD_NS / 4;
  localparam int QUARTER_RAW   = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUARTER_CYC   = (QUARTER_RAW < 1) ? 1 : QUARTER_RAW;

  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATE    = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_DATA     = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 3'h4;

  // serial_control field positions
  localparam int CTL_STEP  = 7;
  localparam int CTL_ACK   = 6;
  localparam int CTL_STA   = 5;
  localparam int CTL_STO   = 4;
  localparam int CTL_WCOL  = 3;
  localparam int CTL_EN    = 2;
  localparam int CTL_IE    = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int RW_BIT    = 0;
  localparam int BYTE_MSB  = 7;

  // bus_state_register codes, prescaler bits always zero
  localparam logic [7:0] ST_START   = 8'h08;
  localparam logic [7:0] ST_RSTART  = 8'h10;
  localparam logic [7:0] ST_AW_ACK  = 8'h18;
  localparam logic [7:0] ST_AW_NACK = 8'h20;
  localparam logic [7:0] ST_D_ACK   = 8'h28;
  localparam logic [7:0] ST_D_NACK  = 8'h30;
  localparam logic [7:0] ST_ARB     = 8'h38;
  localparam logic [7:0] ST_AR_ACK  = 8'h40;
  localparam logic [7:0] ST_AR_NACK = 8'h48;
  localparam logic [7:0] ST_IDLE    = 8'hF8;

  // interrupt event bits
  localparam int EV_W    = 3;
  localparam int EV_STEP = 0;
  localparam int EV_WCOL = 1;
  localparam int EV_ARB  = 2;

  localparam logic [1:0] STEP_LAST = 2'h3;
  localparam logic [1:0] STOP_LAST = 2'h2;
  localparam logic [1:0] STEP_WAIT = 2'h2;

  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WBIT, OP_RBIT} tw_op_e;

endpackage

// [common/tw_bit_if.sv]
// request and answer between the byte sequencer and the bus bit engine
`timescale 1ns/1ps
`default_nettype none
interface tw_bit_if;
  logic           req;
  logic           abort;
  tw_pkg::tw_op_e op;
  logic           bit_tx;
  logic           done;
  logic           bit_rx;
  logic           arb_lost;

  modport ctl (output req, abort, op, bit_tx, input done, bit_rx, arb_lost);
  modport eng (input req, abort, op, bit_tx, output done, bit_rx, arb_lost);
endinterface
`default_nettype wire

// [hdl/tw_bit_engine.sv]
// bus bit engine: start, stop and single bits on the open-drain clock and data lines
`timescale 1ns/1ps
`default_nettype none
module tw_bit_engine #(
  parameter int QUARTER_CYC = tw_pkg::QUARTER_CYC
) (
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  input  wire logic  ce,
  input  wire logic  scl_s,
  input  wire logic  sda_s,
  output logic       scl_oe,
  output logic       sda_oe,
  tw_bit_if.eng      bi
);

  typedef struct packed {
    logic           run;
    tw_pkg::tw_op_e op;
    logic [1:0]     step;
    logic [7:0]     tmr;
    logic           bit_tx;
    logic           scl_oe;
    logic           sda_oe;
    logic           rx;
    logic           done;
    logic           arb;
  } tw_eng_s;

  tw_eng_s r_reg;
  tw_eng_s r_next;

  localparam logic [7:0] TMR_LAST = 8'(QUARTER_CYC - 1);

  always_comb
  begin
    logic stall;
    logic [1:0] last;
    stall = 1'b0;
    last  = (r_reg.op == tw_pkg::OP_STOP) ? tw_pkg::STOP_LAST : tw_pkg::STEP_LAST;
    r_next = r_reg;
    r_next.done = 1'b0;
    if (bi.abort)
    begin
      r_next.run    = 1'b0;
      r_next.scl_oe = 1'b0;
      r_next.sda_oe = 1'b0;
    end
    else if (!r_reg.run)
    begin
      if (bi.req)
      begin
        r_next.run    = 1'b1;
        r_next.op     = bi.op;
        r_next.bit_tx = bi.bit_tx;
        r_next.step   = '0;
        r_next.tmr    = '0;
        r_next.arb    = 1'b0;
      end
    end
    else
    begin
      // a slave may hold the clock low; wait until it lets go
      stall = (r_reg.step == tw_pkg::STEP_WAIT) && (r_reg.tmr == '0) && !scl_s;
      if (!stall && r_reg.tmr == '0)
      begin
        case (r_reg.step)
          2'h0:
          begin
            if (r_reg.op == tw_pkg::OP_START)
              r_next.sda_oe = 1'b0;
            else if (r_reg.op == tw_pkg::OP_STOP)
              r_next.sda_oe = 1'b1;
            else
              r_next.sda_oe = (r_reg.op == tw_pkg::OP_WBIT) && !r_reg.bit_tx;
          end
          2'h1:
            r_next.scl_oe = 1'b0;
          2'h2:
          begin
            if (r_reg.op == tw_pkg::OP_START)
              r_next.sda_oe = 1'b1;
            else if (r_reg.op == tw_pkg::OP_STOP)
              r_next.sda_oe = 1'b0;
            else
            begin
              r_next.rx  = sda_s;
              // sent a one, line shows zero: someone else owns the bus
              r_next.arb = (r_reg.op == tw_pkg::OP_WBIT) && r_reg.bit_tx && !sda_s;
            end
          end
          default:
          begin
            r_next.scl_oe = !r_reg.arb;
            if (r_reg.arb)
              r_next.sda_oe = 1'b0;
          end
        endcase
      end
      if (!stall)
      begin
        if (r_reg.tmr == TMR_LAST)
        begin
          r_next.tmr = '0;
          if (r_reg.step == last)
          begin
            r_next.run  = 1'b0;
            r_next.done = 1'b1;
          end
          else
            r_next.step = r_reg.step + 2'h1;
        end
        else
          r_next.tmr = r_reg.tmr + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      r_reg <= '0;
    else if (ce)
      r_reg <= r_next;
  end

  assign scl_oe      = r_reg.scl_oe;
  assign sda_oe      = r_reg.sda_oe;
  assign bi.done     = r_reg.done;
  assign bi.bit_rx   = r_reg.rx;
  assign bi.arb_lost = r_reg.arb;

endmodule
`default_nettype wire

// [hdl/tw_master_tx.sv]
// two-wire master transmitter: registers, byte sequencer and bus-free watch
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - clearing step flag with start and enable waits for free bus, sends START.
// - after START the step flag sets and state reads 0x08.
// - address read/write bit chooses send mode or receive mode.
// - after address and acknowledge, flag sets with 0x18, 0x20 or 0x38, or with 0x40 or 0x48 for a read address.
// - data write while flag low is dropped and sets write collision.
// - writing one to the step flag clears it and lets the transfer go on.
// - clear with stop only sends STOP mid-transfer and clears stop request itself; when idle it just clears the request.
// - clear with start and stop mid-transfer sends STOP, then START, clears stop request; when idle it sends START only and leaves the stop request set.
// - clear with start only mid-transfer sends repeated START, state 0x10.
// - in 0x10 an address byte is sent; read bit moves to receive mode.
// - in 0x18 to 0x30 a plain clear sends the loaded byte, samples acknowledge.
// - after each data byte flag sets with 0x28, 0x30 or 0x38.
// - after arbitration loss release bus, or with start wait free and START.
// - while the step flag stays set the bus transfer stays suspended.
module tw_master_tx #(
  parameter int QUARTER_CYC = tw_pkg::QUARTER_CYC
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire logic [tw_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [7:0]                rdata,
  output logic                           irq,
  input  wire logic                      scl_in,
  output logic                           scl_out,
  output logic                           scl_oe,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe
);

  typedef enum logic [2:0] {M_IDLE, M_WAIT, M_START, M_HOLD, M_BIT, M_ACK, M_STOP} tw_mst_e;

  typedef struct packed {
    tw_mst_e            st;
    logic [7:0]         ctrl;
    logic [7:0]         code;
    logic [7:0]         data;
    logic [7:0]         shift;
    logic [2:0]         bitn;
    logic               addr_ph;
    logic               rx_mode;
    logic               owned;
    logic               issued;
    logic [tw_pkg::EV_W-1:0] irq_st;
    logic [tw_pkg::EV_W-1:0] irq_mask;
    logic [7:0]         rdata;
    logic [2:0]         scl_sy;
    logic [2:0]         sda_sy;
    logic               busy;
  } tw_top_s;

  tw_top_s r_reg;
  tw_top_s r_next;

  tw_bit_if bi ();

  logic scl_s;
  logic sda_s;
  assign scl_s = r_reg.scl_sy[1];
  assign sda_s = r_reg.sda_sy[1];

  tw_bit_engine #(
    .QUARTER_CYC (QUARTER_CYC)
  ) u_eng (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .scl_s   (scl_s),
    .sda_s   (sda_s),
    .scl_oe  (scl_oe),
    .sda_oe  (sda_oe),
    .bi      (bi)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // engine requests

  always_comb
  begin
    bi.req    = 1'b0;
    bi.op     = tw_pkg::OP_START;
    bi.bit_tx = 1'b1;
    case (r_reg.st)
      M_START:
        bi.req = !r_reg.issued;
      M_STOP:
      begin
        bi.req = !r_reg.issued;
        bi.op  = tw_pkg::OP_STOP;
      end
      M_BIT:
      begin
        bi.req    = !r_reg.issued;
        bi.op     = tw_pkg::OP_WBIT;
        bi.bit_tx = r_reg.shift[tw_pkg::BYTE_MSB];
      end
      M_ACK:
      begin
        bi.req = !r_reg.issued;
        bi.op  = tw_pkg::OP_RBIT;
      end
      default:
        bi.req = 1'b0;
    endcase
  end

  assign bi.abort = !r_reg.ctrl[tw_pkg::CTL_EN];

  ////////////////////////////////////////////////////////////////////////////////
  // registers and sequencer

  always_comb
  begin
    logic go;
    logic hw_step;
    logic ev_wcol;
    logic ev_arb;
    logic ack;
    go      = 1'b0;
    hw_step = 1'b0;
    ev_wcol = 1'b0;
    ev_arb  = 1'b0;
    ack     = !bi.bit_rx;
    r_next  = r_reg;
    r_next.rdata = '0;

    // first stage feeds only the second; stage two and three give edges
    r_next.scl_sy = {r_reg.scl_sy[1:0], scl_in};
    r_next.sda_sy = {r_reg.sda_sy[1:0], sda_in};
    if (scl_s && r_reg.scl_sy[2])
    begin
      if (r_reg.sda_sy[2] && !sda_s)
        r_next.busy = 1'b1;
      else if (!r_reg.sda_sy[2] && sda_s)
        r_next.busy = 1'b0;
    end

    if (wr)
    begin
      case (addr)
        tw_pkg::ADDR_CTRL:
        begin
          r_next.ctrl[tw_pkg::CTL_ACK] = wdata[tw_pkg::CTL_ACK];
          r_next.ctrl[tw_pkg::CTL_STA] = wdata[tw_pkg::CTL_STA];
          r_next.ctrl[tw_pkg::CTL_STO] = wdata[tw_pkg::CTL_STO];
          r_next.ctrl[tw_pkg::CTL_EN]  = wdata[tw_pkg::CTL_EN];
          r_next.ctrl[tw_pkg::CTL_IE]  = wdata[tw_pkg::CTL_IE];
          if (wdata[tw_pkg::CTL_STEP])
            r_next.ctrl[tw_pkg::CTL_STEP] = 1'b0;
          go = wdata[tw_pkg::CTL_STEP] && wdata[tw_pkg::CTL_EN];
        end
        tw_pkg::ADDR_DATA:
        begin
          if (r_reg.ctrl[tw_pkg::CTL_STEP])
          begin
            r_next.data = wdata;
            r_next.ctrl[tw_pkg::CTL_WCOL] = 1'b0;
          end
          else
            ev_wcol = 1'b1;
        end
        tw_pkg::ADDR_IRQ_STAT:
          r_next.irq_st = r_reg.irq_st & ~wdata[tw_pkg::EV_W-1:0];
        tw_pkg::ADDR_IRQ_MASK:
          r_next.irq_mask = wdata[tw_pkg::EV_W-1:0];
        default:
          r_next.irq_mask = r_reg.irq_mask;
      endcase
    end

    if (rd)
    begin
      case (addr)
        tw_pkg::ADDR_CTRL:     r_next.rdata = r_reg.ctrl;
        tw_pkg::ADDR_STATE:    r_next.rdata = r_reg.code;
        tw_pkg::ADDR_DATA:     r_next.rdata = r_reg.data;
        tw_pkg::ADDR_IRQ_STAT: r_next.rdata = 8'(r_reg.irq_st);
        tw_pkg::ADDR_IRQ_MASK: r_next.rdata = 8'(r_reg.irq_mask);
        default:               r_next.rdata = '0;
      endcase
    end

    if (bi.req)
      r_next.issued = 1'b1;

    case (r_reg.st)
      M_IDLE:
      begin
        if (go && wdata[tw_pkg::CTL_STA])
        begin
          r_next.st = M_WAIT;
        end
        else if (go && wdata[tw_pkg::CTL_STO])
          r_next.ctrl[tw_pkg::CTL_STO] = 1'b0;
      end
      M_WAIT:
      begin
        if (!r_reg.busy)
        begin
          r_next.st     = M_START;
          r_next.issued = 1'b0;
        end
      end
      M_START:
      begin
        if (bi.done)
        begin
          r_next.code    = r_reg.owned ? tw_pkg::ST_RSTART : tw_pkg::ST_START;
          r_next.owned   = 1'b1;
          r_next.addr_ph = 1'b1;
          r_next.rx_mode = 1'b0;
          r_next.st      = M_HOLD;
          hw_step        = 1'b1;
        end
      end
      M_HOLD:
      begin
        // nothing moves on the bus until software clears the flag
        if (go)
        begin
          r_next.issued = 1'b0;
          if (r_reg.code == tw_pkg::ST_ARB)
            r_next.st = wdata[tw_pkg::CTL_STA] ? M_WAIT : M_IDLE;
          else if (wdata[tw_pkg::CTL_STO])
            r_next.st = M_STOP;
          else if (wdata[tw_pkg::CTL_STA])
            r_next.st = M_START;
          else if (!r_reg.rx_mode)
          begin
            r_next.shift = r_reg.data;
            r_next.bitn  = 3'(tw_pkg::BYTE_MSB);
            r_next.st    = M_BIT;
          end
        end
      end
      M_BIT:
      begin
        if (bi.done)
        begin
          r_next.issued = 1'b0;
          if (bi.arb_lost)
          begin
            r_next.code  = tw_pkg::ST_ARB;
            r_next.owned = 1'b0;
            r_next.st    = M_HOLD;
            ev_arb       = 1'b1;
            hw_step      = 1'b1;
          end
          else
          begin
            r_next.shift = {r_reg.shift[6:0], 1'b0};
            if (r_reg.bitn == '0)
              r_next.st = M_ACK;
            else
              r_next.bitn = r_reg.bitn - 3'h1;
          end
        end
      end
      M_ACK:
      begin
        if (bi.done)
        begin
          if (r_reg.addr_ph && r_reg.data[tw_pkg::RW_BIT])
          begin
            r_next.code    = ack ? tw_pkg::ST_AR_ACK : tw_pkg::ST_AR_NACK;
            r_next.rx_mode = 1'b1;
          end
          else if (r_reg.addr_ph)
            r_next.code = ack ? tw_pkg::ST_AW_ACK : tw_pkg::ST_AW_NACK;
          else
            r_next.code = ack ? tw_pkg::ST_D_ACK : tw_pkg::ST_D_NACK;
          r_next.addr_ph = 1'b0;
          r_next.st      = M_HOLD;
          hw_step        = 1'b1;
        end
      end
      M_STOP:
      begin
        if (bi.done)
        begin
          r_next.ctrl[tw_pkg::CTL_STO] = 1'b0;
          r_next.owned  = 1'b0;
          r_next.issued = 1'b0;
          // a start still pending follows the stop once the bus is free
          if (r_reg.ctrl[tw_pkg::CTL_STA])
            r_next.st = M_WAIT;
          else
          begin
            r_next.code = tw_pkg::ST_IDLE;
            r_next.st   = M_IDLE;
          end
        end
      end
      default:
        r_next.st = M_IDLE;
    endcase

    // disabling drops the transfer; the engine releases both lines
    if (!r_next.ctrl[tw_pkg::CTL_EN])
    begin
      r_next.st    = M_IDLE;
      r_next.owned = 1'b0;
    end

    // hardware sets win over software clears in the same cycle
    if (hw_step)
    begin
      r_next.ctrl[tw_pkg::CTL_STEP] = 1'b1;
      r_next.irq_st[tw_pkg::EV_STEP] = 1'b1;
    end
    if (ev_wcol)
    begin
      r_next.ctrl[tw_pkg::CTL_WCOL] = 1'b1;
      r_next.irq_st[tw_pkg::EV_WCOL] = 1'b1;
    end
    if (ev_arb)
      r_next.irq_st[tw_pkg::EV_ARB] = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_reg        <= '0;
      r_reg.st     <= M_IDLE;
      r_reg.ctrl   <= tw_pkg::CTRL_RESET;
      r_reg.code   <= tw_pkg::ST_IDLE;
      r_reg.scl_sy <= 3'h7;
      r_reg.sda_sy <= 3'h7;
    end
    else if (ce)
      r_reg <= r_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata   = r_reg.rdata;
  assign irq     = (|(r_reg.irq_st & r_reg.irq_mask))
                 | (r_reg.ctrl[tw_pkg::CTL_STEP] & r_reg.ctrl[tw_pkg::CTL_IE]);
  // open drain: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

endmodule
`default_nettype wire

// [sim/tw_slave_model.sv]
// behavioural slave receiver on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module tw_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       nack,
  output logic            sda_pull,
  output logic [7:0]      got_byte,
  output int              n_stop
);
  int         cnt = 0;
  logic [7:0] shift_q = 8'h00;
  initial
  begin
    sda_pull = 1'b0;
    got_byte = 8'h00;
    n_stop = 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // start and stop are seen only while the clock line is high
  always @(negedge sda)
    if (scl === 1'b1)
      cnt = 0;
  always @(posedge sda)
    if (scl === 1'b1)
    begin
      cnt = 0;
      n_stop = n_stop + 1;
    end
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge scl)
  begin
    if (cnt < 8)
      shift_q = {shift_q[6:0], sda};
    cnt = cnt + 1;
  end
  // pull only in the ack slot; released line floats up through the pull-up
  always @(negedge scl)
  begin
    sda_pull = (cnt == 8) && !nack;
    if (cnt == 8)
      got_byte = shift_q;
    if (cnt == 9)
      cnt = 0;
  end
endmodule
`default_nettype wire

// [sim/tw_master_tx_monitor.sv]
// concurrent checks on the ports of the two-wire master transmitter
`timescale 1ns/1ps
`default_nettype none
module tw_master_tx_monitor #(
  parameter int QUARTER_CYC = tw_pkg::QUARTER_CYC
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire logic [tw_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  input  wire logic [7:0]                rdata,
  input  wire logic                      irq,
  input  wire logic                      scl_in,
  input  wire logic                      scl_out,
  input  wire logic                      scl_oe,
  input  wire logic                      sda_in,
  input  wire logic                      sda_out,
  input  wire logic                      sda_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // shadows of enables, so irq can be tied to the step flag alone
  logic                    ie_sh;
  logic [tw_pkg::EV_W-1:0] mask_sh;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ie_sh <= 1'b0;
      mask_sh <= '0;
    end
    else if (ce && wr)
    begin
      if (addr == tw_pkg::ADDR_CTRL)
        ie_sh <= wdata[tw_pkg::CTL_IE];
      if (addr == tw_pkg::ADDR_IRQ_MASK)
        mask_sh <= wdata[tw_pkg::EV_W-1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_idle: assert property ($rose(rst_n) |-> !scl_oe && !sda_oe && !irq && rdata == 8'h00)
    else $error("outputs not idle after reset");
  a_rdata_one_cycle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_state_low_zero: assert property (rd && addr == tw_pkg::ADDR_STATE |=> rdata[2:0] == 3'h0)
    else $error("prescaler bits of state not zero");
  a_start_free_bus: assert property ($rose(sda_oe) && !scl_oe |-> $past(sda_in) ##[1:8] scl_oe)
    else $error("start not on a free bus or clock not pulled");
  a_step_after_start: assert property ($rose(sda_oe) && !scl_oe && ie_sh && mask_sh == 3'h0
    |-> ##[1:16] irq)
    else $error("step flag missing after start");
  a_hold_while_step: assert property (irq && $past(irq) && ie_sh && mask_sh == 3'h0
    && !$past(wr) && !$past(wr, 2) |-> $stable(scl_oe) && $stable(sda_oe))
    else $error("bus moved while step flag set");
  a_wcol_irq: assert property (ce && wr && addr == tw_pkg::ADDR_DATA && !irq && ie_sh
    && mask_sh[tw_pkg::EV_WCOL] |=> irq)
    else $error("write collision not flagged");
  a_stop_no_step: assert property ($fell(sda_oe) && !scl_oe && !$past(scl_oe) && ie_sh
    && mask_sh == 3'h0 |-> !irq [*4])
    else $error("step flag set after stop");
  a_irq_needs_enable: assert property (irq |-> ie_sh || mask_sh != 3'h0)
    else $error("irq without an enable");
  a_pins_low: assert property (!scl_out && !sda_out)
    else $error("open-drain pin data not low");
  c_start: cover property ($rose(sda_oe) && !scl_oe);
  c_stop: cover property ($fell(sda_oe) && !scl_oe && !$past(scl_oe));
  c_wcol: cover property (wr && addr == tw_pkg::ADDR_DATA && !irq && ie_sh);
endmodule
`default_nettype wire

// [sim/tb_two_wire_master_transmitter.sv]
// testbench of the two-wire master transmitter against a slave receiver model
`timescale 1ns/1ps
`default_nettype none
module tb_two_wire_master_transmitter;
  logic                      ref_clk = 1'b0;
  logic                      rst_n = 1'b0;
  logic                      ce = 1'b1;
  logic [tw_pkg::ADDR_W-1:0] addr = '0;
  logic [7:0]                wdata = 8'h00;
  logic                      wr = 1'b0;
  logic                      rd = 1'b0;
  logic [7:0]                rdata;
  logic                      irq;
  logic                      scl_oe;
  logic                      sda_oe;
  logic                      nack = 1'b0;
  logic                      jam = 1'b0;
  logic                      slv_pull;
  logic [7:0]                got_byte;
  int                        n_stop;
  int                        num_errors = 0;
  int                        n_tests = 0;
  // open drain with pull-ups; jam stands in for a rival master
  wire                       scl_line = ~scl_oe;
  wire                       sda_line = ~(sda_oe | slv_pull | jam);
  always #12.5 ref_clk = ~ref_clk;
  tw_master_tx tw_master_tx_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .scl_in(scl_line),
    .scl_out(), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe));
  tw_slave_model tw_slave_model_inst (.scl(scl_line), .sda(sda_line), .nack(nack),
    .sda_pull(slv_pull), .got_byte(got_byte), .n_stop(n_stop));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // trailing idle cycle keeps strobes from being set twice in one step
  task automatic wr_reg(input logic [tw_pkg::ADDR_W-1:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd_chk(input logic [tw_pkg::ADDR_W-1:0] a, input logic [7:0] m,
                        input logic [7:0] exp, input string nm);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    chk(nm, exp, rdata & m);
    @(posedge ref_clk);
  endtask
  task automatic wait_step;
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 3000)
    begin
      @(posedge ref_clk);
      i++;
    end
    chk("step flag", 8'h01, {7'h0, irq});
  endtask
  task automatic step(input logic [7:0] c, input logic [7:0] st, input string nm);
    wr_reg(tw_pkg::ADDR_CTRL, c);
    wait_step;
    rd_chk(tw_pkg::ADDR_STATE, 8'hFF, st, nm);
  endtask
  task automatic stop_seen(input int ns);
    int i;
    i = 0;
    while (n_stop == ns && i < 3000)
    begin
      @(posedge ref_clk);
      i++;
    end
    chk("stop count", 8'h01, 8'(n_stop - ns));
    // stop request clears only once the engine reports the stop done
    repeat (4) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd_chk(tw_pkg::ADDR_CTRL, 8'hFF, tw_pkg::CTRL_RESET, "ctrl reset");
    rd_chk(tw_pkg::ADDR_STATE, 8'hFF, tw_pkg::ST_IDLE, "state reset");
    rd_chk(tw_pkg::ADDR_IRQ_MASK, 8'hFF, 8'h00, "mask reset");
    wr_reg(3'h5, 8'hFF);
    rd_chk(3'h5, 8'hFF, 8'h00, "unmapped");
    wr_reg(tw_pkg::ADDR_CTRL, 8'h45);
    rd_chk(tw_pkg::ADDR_CTRL, 8'hFF, 8'h45, "ctrl rw");
    ce <= 1'b0;
    wr_reg(tw_pkg::ADDR_CTRL, 8'h00);
    ce <= 1'b1;
    rd_chk(tw_pkg::ADDR_CTRL, 8'hFF, 8'h45, "ce freeze");
  endtask
  task automatic t_send;
    int ns;
    step(8'hA5, tw_pkg::ST_START, "start");
    wr_reg(tw_pkg::ADDR_DATA, 8'hA4);
    step(8'h85, tw_pkg::ST_AW_ACK, "addr ack");
    chk("slave addr", 8'hA4, got_byte);
    wr_reg(tw_pkg::ADDR_DATA, 8'h3C);
    nack <= 1'b1;
    step(8'h85, tw_pkg::ST_D_NACK, "data nack");
    chk("slave data", 8'h3C, got_byte);
    nack <= 1'b0;
    wr_reg(tw_pkg::ADDR_DATA, 8'h5B);
    step(8'h85, tw_pkg::ST_D_ACK, "data ack");
    step(8'hA5, tw_pkg::ST_RSTART, "rstart");
    nack <= 1'b1;
    wr_reg(tw_pkg::ADDR_DATA, 8'hA4);
    step(8'h85, tw_pkg::ST_AW_NACK, "addr nack");
    nack <= 1'b0;
    ns = n_stop;
    step(8'hB5, tw_pkg::ST_START, "stop start");
    chk("stop before start", 8'h01, 8'(n_stop - ns));
    rd_chk(tw_pkg::ADDR_CTRL, 8'h10, 8'h00, "stop bit cleared");
    wr_reg(tw_pkg::ADDR_DATA, 8'hA5);
    step(8'h85, tw_pkg::ST_AR_ACK, "addr read");
    ns = n_stop;
    wr_reg(tw_pkg::ADDR_CTRL, 8'h95);
    stop_seen(ns);
    rd_chk(tw_pkg::ADDR_CTRL, 8'h90, 8'h00, "stop done");
  endtask
  task automatic t_wcol;
    wr_reg(tw_pkg::ADDR_IRQ_MASK, 8'h02);
    wr_reg(tw_pkg::ADDR_DATA, 8'h77);
    chk("wcol irq", 8'h01, {7'h0, irq});
    rd_chk(tw_pkg::ADDR_CTRL, 8'h08, 8'h08, "wcol bit");
    rd_chk(tw_pkg::ADDR_DATA, 8'hFF, 8'hA5, "data kept");
    wr_reg(tw_pkg::ADDR_IRQ_MASK, 8'h00);
    chk("masked irq", 8'h00, {7'h0, irq});
    wr_reg(tw_pkg::ADDR_IRQ_STAT, 8'h02);
    rd_chk(tw_pkg::ADDR_IRQ_STAT, 8'h02, 8'h00, "status cleared");
  endtask
  task automatic t_arb;
    int ns;
    step(8'hA5, tw_pkg::ST_START, "start again");
    jam <= 1'b1;
    wr_reg(tw_pkg::ADDR_DATA, 8'h80);
    step(8'h85, tw_pkg::ST_ARB, "arb lost");
    chk("lines free", 8'h00, {6'h0, scl_oe, sda_oe});
    rd_chk(tw_pkg::ADDR_IRQ_STAT, 8'h04, 8'h04, "arb status");
    wr_reg(tw_pkg::ADDR_CTRL, 8'hA5);
    // absence check: no start may appear while the rival holds the bus
    repeat (100) @(posedge ref_clk);
    chk("held off", 8'h00, {7'h0, irq});
    jam <= 1'b0;
    wait_step;
    rd_chk(tw_pkg::ADDR_STATE, 8'hFF, tw_pkg::ST_START, "start when free");
    ns = n_stop;
    wr_reg(tw_pkg::ADDR_CTRL, 8'h95);
    stop_seen(ns);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs;
    t_send;
    t_wcol;
    t_arb;
    final_report;
  end
  initial
  begin
    #(25 * 40000);
    num_errors++;
    final_report;
  end
endmodule
bind tw_master_tx tw_master_tx_monitor #(.QUARTER_CYC(QUARTER_CYC)) tw_master_tx_monitor_inst (
  .ref_clk, .rst_n, .ce, .addr, .wdata, .wr, .rd, .rdata, .irq, .scl_in, .scl_out, .scl_oe,
  .sda_in, .sda_out, .sda_oe);
`default_nettype wire
